// ### src/config_fuse_bank_map.vh
// Register indexes, bit positions, masks and sizes of the configuration fuse bank.
`ifndef CONFIG_FUSE_BANK_MAP_VH
`define CONFIG_FUSE_BANK_MAP_VH

// Register indexes; the APB byte address is four times the index.
`define IDX_PIN_SERIAL 24'h300005
`define IDX_DEBUG_BOOT 24'h300006
`define IDX_BLOCK_RD_PROT 24'h300008
`define IDX_DATA_BOOT_PROT 24'h300009
`define IDX_BLOCK_WR_PROT 24'h30000a

// Pin and serial byte fields.
`define BIT_RESET_PIN_ENABLE 7
`define BIT_SERIAL_MASK_MODE 3
`define BIT_CAPTURE_OUTPUT_MUX 1
`define BIT_SECOND_CAPTURE_MUX 0

// Debug, boot and stack byte fields.
`define BIT_DEBUG_DISABLE 7
`define BIT_BOOT_SIZE_SELECT 4
`define BIT_STACK_FAULT_RESET 0

// Data and boot protection byte fields.
`define BIT_DATA_MEMORY_PROTECT 7
`define BIT_BOOT_BLOCK_PROTECT 6

// Implemented positions of each byte.
`define IMPL_PIN_SERIAL_FULL 8'h8b
`define IMPL_PIN_SERIAL_SMALL 8'h89
`define IMPL_DEBUG_BOOT 8'h91
`define IMPL_BLOCKS_LARGE 8'hff
`define IMPL_BLOCKS_SMALL 8'h0f
`define IMPL_DATA_BOOT 8'hc0

// Value every protection bit holds when unprogrammed.
`define PROT_ERASED 8'hff

// Boot block sizes in words.
`define BOOT_WORDS_SMALL 24'h000400
`define BOOT_WORDS_LARGE 24'h000800

// Serial slave address compare masks.
`define SERIAL_MASK_7BIT 7'h7f
`define SERIAL_MASK_5BIT 7'h1f

`endif

// ### src/config_fuse_bank.v
// Configuration fuse bank: captured fuse bytes, pin routing, protection checks, APB view.
//
// How it works
// - Reset pin enable picks reset or port G5 input
// - Unimplemented fuse positions always read zero
// - Mask mode picks 7-bit or 5-bit masking
// - Mux set routes capture outputs onto port E
// - Mux clear routes capture outputs onto port H
// - Second capture mux set selects port C1
// - Otherwise port B3 extended, E7 plain mode
// - Debug bit clear claims port B6 and B7
// - Boot size bit gives 2 kW or 1 kW
// - Stack fault reset bit lets stack faults reset
// - Read protect bit n zero guards block n
// - Blocks four to seven exist on large parts
// - Data memory protect bit zero guards data memory
// - Boot protect bit zero guards boot block reads
// - Boot protected region follows boot size select
// - Protection bits load from the fuses at reset and only clear
// - Capture output mux absent on small pin parts
// - Units seven and nine absent on small memory
// - Write protect bit n zero blocks self-writes
`timescale 1ns/100ps
`include "config_fuse_bank_map.vh"

module config_fuse_bank #(
  parameter LARGE_MEMORY = 1,
  parameter FULL_PIN_COUNT = 1,
  parameter SMALL_MEMORY = 0,
  parameter PM_ADDR_W = 24,
  parameter BLOCK_SHIFT = 14
) (
  // Clock and synchronous reset.
  input wire CLK_SYS,
  input wire SRST,
  // APB slave.
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [31:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Raw fuse bytes from non-volatile storage.
  input wire [7:0] NV_PIN_SERIAL,
  input wire [7:0] NV_DEBUG_BOOT,
  input wire [7:0] NV_BLOCK_RD_PROT,
  input wire [7:0] NV_DATA_BOOT_PROT,
  input wire [7:0] NV_BLOCK_WR_PROT,
  // External reset pin, active low, asynchronous.
  input wire EXTERNAL_RESET_PIN_N,
  output reg PIN_RESET_REQ,
  output reg PORT_G_BIT5_IN,
  output reg PORT_G_BIT5_IS_INPUT,
  // Serial port address mask.
  output reg [6:0] SERIAL_ADDR_MASK,
  // Capture unit outputs and their steering.
  input wire UNIT1_OUTPUT_B,
  input wire UNIT1_OUTPUT_C,
  input wire UNIT3_OUTPUT_B,
  input wire UNIT3_OUTPUT_C,
  input wire CAPTURE_UNIT6,
  input wire CAPTURE_UNIT7,
  input wire CAPTURE_UNIT8,
  input wire CAPTURE_UNIT9,
  input wire UNIT1_STEERED,
  input wire UNIT3_STEERED,
  // Routed capture pins: port E bits 6..3 and port H bits 7..4.
  output reg [3:0] PORT_E_CAPTURE_OUT,
  output reg [3:0] PORT_E_CAPTURE_OE,
  output reg [3:0] PORT_H_CAPTURE_OUT,
  output reg [3:0] PORT_H_CAPTURE_OE,
  // Second enhanced capture unit pin choice.
  input wire EXT_BUS_MODE,
  output reg UNIT2_ON_PORT_C_BIT1,
  output reg UNIT2_ON_PORT_B_BIT3,
  output reg UNIT2_ON_PORT_E_BIT7,
  // Debugger pins.
  output reg DEBUG_OWNS_PORT_B67,
  // Boot block size.
  output reg BOOT_SIZE_2KW,
  // Stack faults.
  input wire STACK_FULL,
  input wire STACK_UNDERFLOW,
  output reg STACK_RESET_REQ,
  // Program and data memory access checks.
  input wire [PM_ADDR_W-1:0] PM_ADDR,
  input wire PM_EXT_READ,
  input wire PM_SELF_WRITE,
  output reg PM_READ_DENIED,
  output reg PM_WRITE_DENIED,
  output reg DATA_MEMORY_PROTECTED
);

  // Implemented bit masks depend on the family member.
  localparam [7:0] impl_pin_serial = FULL_PIN_COUNT ? `IMPL_PIN_SERIAL_FULL :
    `IMPL_PIN_SERIAL_SMALL;
  localparam [7:0] impl_blocks = LARGE_MEMORY ? `IMPL_BLOCKS_LARGE :
    `IMPL_BLOCKS_SMALL;

  // Held copies of each fuse byte, already masked to implemented bits.
  reg [7:0] pin_serial_r;
  reg [7:0] debug_boot_r;
  reg [7:0] rd_prot_r;
  reg [7:0] rd_prot_nxt;
  reg [7:0] data_boot_r;
  reg [7:0] data_boot_nxt;
  reg [7:0] wr_prot_r;
  reg [7:0] wr_prot_nxt;

  // Reset pin synchroniser; only the second stage is looked at.
  reg rst_pin_s1_r;
  reg rst_pin_s2_r;

  // APB decode results.
  reg [31:0] rd_word;
  reg hit;
  wire [23:0] idx = PADDR[25:2];
  wire addr_ok = (PADDR[31:26] == 6'h00) && (PADDR[1:0] == 2'h0);
  wire access = PSEL && PENABLE;
  wire commit = access && PREADY;

  // Fuses are sampled while reset is held and then frozen, so routing and
  // protection cannot change under running code; only clears may follow.
  always @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      pin_serial_r <= NV_PIN_SERIAL & impl_pin_serial;
      debug_boot_r <= NV_DEBUG_BOOT & `IMPL_DEBUG_BOOT;
      rd_prot_r <= NV_BLOCK_RD_PROT & impl_blocks;
      data_boot_r <= NV_DATA_BOOT_PROT & `IMPL_DATA_BOOT;
      wr_prot_r <= NV_BLOCK_WR_PROT & impl_blocks;
    end
    else
    begin
      // Held bytes are read-only; protection bytes take clears only.
      rd_prot_r <= rd_prot_nxt;
      data_boot_r <= data_boot_nxt;
      wr_prot_r <= wr_prot_nxt;
    end
  end

  // A committed write can only drop protection bits: a zero in the data
  // clears, a one leaves the bit as it was, so nothing is ever reopened.
  always @*
  begin
    rd_prot_nxt = rd_prot_r;
    data_boot_nxt = data_boot_r;
    wr_prot_nxt = wr_prot_r;
    if (commit && PWRITE && addr_ok)
    begin
      if (idx == `IDX_BLOCK_RD_PROT)
        rd_prot_nxt = rd_prot_r & PWDATA[7:0];
      if (idx == `IDX_DATA_BOOT_PROT)
        data_boot_nxt = data_boot_r & PWDATA[7:0];
      if (idx == `IDX_BLOCK_WR_PROT)
        wr_prot_nxt = wr_prot_r & PWDATA[7:0];
    end
  end

  // Read mux; bytes sit in the low lane and upper bits read as zero.
  always @*
  begin
    rd_word = 32'h00000000;
    hit = addr_ok;
    case (idx)
      `IDX_PIN_SERIAL: rd_word = {24'h000000, pin_serial_r};
      `IDX_DEBUG_BOOT: rd_word = {24'h000000, debug_boot_r};
      `IDX_BLOCK_RD_PROT: rd_word = {24'h000000, rd_prot_r};
      `IDX_DATA_BOOT_PROT: rd_word = {24'h000000, data_boot_r};
      `IDX_BLOCK_WR_PROT: rd_word = {24'h000000, wr_prot_r};
      default: hit = 1'b0;
    endcase
    if (!addr_ok)
      rd_word = 32'h00000000;
  end

  // One wait state: ready is set at the edge ending the first access cycle and the transfer
  // completes on the next edge; the wait keeps read data coming from flops.
  always @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end
    else if (access && !PREADY)
    begin
      PREADY <= 1'b1;
      PSLVERR <= !hit;
      PRDATA <= (PWRITE || !hit) ? 32'h00000000 : rd_word;
    end
    else
    begin
      // Completed or idle: drop the answer.
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end
  end

  // Two-flop synchroniser for the reset pin.
  always @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      rst_pin_s1_r <= 1'b1;
      rst_pin_s2_r <= 1'b1;
    end
    else
    begin
      rst_pin_s1_r <= EXTERNAL_RESET_PIN_N;
      rst_pin_s2_r <= rst_pin_s1_r;
    end
  end

  // Reset pin either asks for reset or serves as a plain input.
  always @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      PIN_RESET_REQ <= 1'b0;
      PORT_G_BIT5_IN <= 1'b0;
      PORT_G_BIT5_IS_INPUT <= 1'b0;
    end
    else if (pin_serial_r[`BIT_RESET_PIN_ENABLE])
    begin
      PIN_RESET_REQ <= !rst_pin_s2_r;
      PORT_G_BIT5_IN <= 1'b0;
      PORT_G_BIT5_IS_INPUT <= 1'b0;
    end
    else
    begin
      PIN_RESET_REQ <= 1'b0;
      PORT_G_BIT5_IN <= rst_pin_s2_r;
      PORT_G_BIT5_IS_INPUT <= 1'b1;
    end
  end

  // Routed values of the two capture pin pairs; the missing units on the
  // smallest parts drive nothing, while the enhanced outputs still route.
  wire pair1_hi = UNIT1_STEERED ? UNIT1_OUTPUT_B : CAPTURE_UNIT6;
  wire pair1_lo = UNIT1_STEERED ? UNIT1_OUTPUT_C : (CAPTURE_UNIT7 && !SMALL_MEMORY);
  wire pair3_hi = UNIT3_STEERED ? UNIT3_OUTPUT_B : CAPTURE_UNIT8;
  wire pair3_lo = UNIT3_STEERED ? UNIT3_OUTPUT_C : (CAPTURE_UNIT9 && !SMALL_MEMORY);
  wire lo_used1 = UNIT1_STEERED || !SMALL_MEMORY;
  wire lo_used3 = UNIT3_STEERED || !SMALL_MEMORY;
  wire [3:0] pair_val = {pair1_hi, pair1_lo, pair3_hi, pair3_lo};
  wire [3:0] pair_use = {1'b1, lo_used1, 1'b1, lo_used3};
  wire to_port_e = pin_serial_r[`BIT_CAPTURE_OUTPUT_MUX];

  // Capture output mux: the same four signals land on port E or port H.
  always @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      PORT_E_CAPTURE_OUT <= 4'h0;
      PORT_E_CAPTURE_OE <= 4'h0;
      PORT_H_CAPTURE_OUT <= 4'h0;
      PORT_H_CAPTURE_OE <= 4'h0;
    end
    else if (to_port_e)
    begin
      PORT_E_CAPTURE_OUT <= pair_val & pair_use;
      PORT_E_CAPTURE_OE <= pair_use;
      PORT_H_CAPTURE_OUT <= 4'h0;
      PORT_H_CAPTURE_OE <= 4'h0;
    end
    else
    begin
      PORT_E_CAPTURE_OUT <= 4'h0;
      PORT_E_CAPTURE_OE <= 4'h0;
      PORT_H_CAPTURE_OUT <= pair_val & pair_use;
      PORT_H_CAPTURE_OE <= pair_use;
    end
  end

  // Second capture unit pin; bus mode is a core signal on this clock.
  always @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      UNIT2_ON_PORT_C_BIT1 <= 1'b0;
      UNIT2_ON_PORT_B_BIT3 <= 1'b0;
      UNIT2_ON_PORT_E_BIT7 <= 1'b0;
    end
    else
    begin
      UNIT2_ON_PORT_C_BIT1 <= pin_serial_r[`BIT_SECOND_CAPTURE_MUX];
      UNIT2_ON_PORT_B_BIT3 <= !pin_serial_r[`BIT_SECOND_CAPTURE_MUX] && EXT_BUS_MODE;
      UNIT2_ON_PORT_E_BIT7 <= !pin_serial_r[`BIT_SECOND_CAPTURE_MUX] && !EXT_BUS_MODE;
    end
  end

  // Static modes: serial mask, debugger pins, boot size, data protection.
  always @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      SERIAL_ADDR_MASK <= `SERIAL_MASK_5BIT;
      DEBUG_OWNS_PORT_B67 <= 1'b0;
      BOOT_SIZE_2KW <= 1'b0;
      DATA_MEMORY_PROTECTED <= 1'b1;
    end
    else
    begin
      SERIAL_ADDR_MASK <= pin_serial_r[`BIT_SERIAL_MASK_MODE] ?
        `SERIAL_MASK_7BIT : `SERIAL_MASK_5BIT;
      DEBUG_OWNS_PORT_B67 <= !debug_boot_r[`BIT_DEBUG_DISABLE];
      BOOT_SIZE_2KW <= debug_boot_r[`BIT_BOOT_SIZE_SELECT];
      DATA_MEMORY_PROTECTED <= !data_boot_r[`BIT_DATA_MEMORY_PROTECT];
    end
  end

  // Stack faults raise a registered reset request, lasting as long as the fault, only when enabled.
  always @(posedge CLK_SYS)
  begin
    if (SRST)
      STACK_RESET_REQ <= 1'b0;
    else
      STACK_RESET_REQ <= debug_boot_r[`BIT_STACK_FAULT_RESET] &&
        (STACK_FULL || STACK_UNDERFLOW);
  end

  // Per-block guard flags; positions absent on small parts never guard.
  wire [7:0] rd_guard;
  wire [7:0] wr_guard;
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1)
    begin : g_block
      assign rd_guard[b] = impl_blocks[b] && !rd_prot_r[b];
      assign wr_guard[b] = impl_blocks[b] && !wr_prot_r[b];
    end
  endgenerate

  // Which block and whether the address falls inside the boot block.
  wire [PM_ADDR_W+2:0] addr_wide = {3'h0, PM_ADDR};
  wire [2:0] blk = addr_wide[BLOCK_SHIFT+2:BLOCK_SHIFT];
  wire [23:0] boot_words = debug_boot_r[`BIT_BOOT_SIZE_SELECT] ?
    `BOOT_WORDS_LARGE : `BOOT_WORDS_SMALL;
  wire [23:0] addr24 = addr_wide[23:0];
  wire in_boot = addr24 < boot_words;
  wire boot_guard = !data_boot_r[`BIT_BOOT_BLOCK_PROTECT];

  // The boot block is carved from block 0 and has its own read guard; self
  // writes inside it fall back to the block 0 write guard held here.
  always @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      PM_READ_DENIED <= 1'b0;
      PM_WRITE_DENIED <= 1'b0;
    end
    else
    begin
      PM_READ_DENIED <= PM_EXT_READ && (in_boot ? boot_guard : rd_guard[blk]);
      PM_WRITE_DENIED <= PM_SELF_WRITE && wr_guard[in_boot ? 3'h0 : blk];
    end
  end

endmodule

// ### verif/config_fuse_bank_assertions.sv
// Concurrent checks on the fuse bank ports.
`timescale 1ns/100ps
module config_fuse_bank_assertions (
  // Clock and reset.
  input logic CLK_SYS,
  input logic SRST,
  // APB slave side.
  input logic PSEL,
  input logic PENABLE,
  input logic [31:0] PRDATA,
  input logic PREADY,
  input logic PSLVERR,
  // Pin routing.
  input logic PIN_RESET_REQ,
  input logic PORT_G_BIT5_IS_INPUT,
  input logic [6:0] SERIAL_ADDR_MASK,
  input logic [3:0] PORT_E_CAPTURE_OE,
  input logic [3:0] PORT_H_CAPTURE_OE,
  input logic UNIT2_ON_PORT_C_BIT1,
  input logic UNIT2_ON_PORT_B_BIT3,
  input logic UNIT2_ON_PORT_E_BIT7
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);

  // The answer lasts exactly one cycle.
  a_ready_one_pulse:
    assert property (PREADY |=> !PREADY) else $error("ready held too long");
  // One wait state after the first access cycle.
  a_ready_after_access:
    assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("ready late");
  // A refused access returns no data.
  a_error_no_data:
    assert property (PSLVERR |-> PREADY && PRDATA == 32'h0) else $error("error data");
  a_upper_lanes_zero:
    assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper lanes set");
  // Captured fuse decisions stay put while running; two edges let the capture land.
  a_fuse_held:
    assert property (!$past(SRST) && !$past(SRST, 2) |-> $stable(SERIAL_ADDR_MASK)
      && $stable(PORT_G_BIT5_IS_INPUT)) else $error("fuse output moved");
  a_gpio_no_reset:
    assert property (PORT_G_BIT5_IS_INPUT |-> !PIN_RESET_REQ) else $error("pin reset as input");
  a_unit2_one_pin:
    assert property (!$past(SRST) |-> $onehot({UNIT2_ON_PORT_C_BIT1, UNIT2_ON_PORT_B_BIT3,
      UNIT2_ON_PORT_E_BIT7})) else $error("second unit pin not unique");
  a_one_port_drives:
    assert property (PORT_E_CAPTURE_OE == 4'h0 || PORT_H_CAPTURE_OE == 4'h0)
      else $error("both ports driven");

  c_refused: cover property (PREADY && PSLVERR);
  c_pin_reset: cover property (PIN_RESET_REQ);
  c_unit2_b3: cover property (UNIT2_ON_PORT_B_BIT3);
endmodule

bind config_fuse_bank config_fuse_bank_assertions config_fuse_bank_assertions_inst (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_RESET_REQ(PIN_RESET_REQ),
  .PORT_G_BIT5_IS_INPUT(PORT_G_BIT5_IS_INPUT), .SERIAL_ADDR_MASK(SERIAL_ADDR_MASK),
  .PORT_E_CAPTURE_OE(PORT_E_CAPTURE_OE), .PORT_H_CAPTURE_OE(PORT_H_CAPTURE_OE),
  .UNIT2_ON_PORT_C_BIT1(UNIT2_ON_PORT_C_BIT1), .UNIT2_ON_PORT_B_BIT3(UNIT2_ON_PORT_B_BIT3),
  .UNIT2_ON_PORT_E_BIT7(UNIT2_ON_PORT_E_BIT7));

// ### verif/config_fuse_bank_tb.sv
// Self-checking bench for the configuration fuse bank.
`timescale 1ns/100ps
`include "config_fuse_bank_map.vh"
module config_fuse_bank_tb;
  // Byte addresses are four times the register index.
  localparam logic [31:0] A_PS = {`IDX_PIN_SERIAL, 2'b00};
  localparam logic [31:0] A_DB = {`IDX_DEBUG_BOOT, 2'b00};
  localparam logic [31:0] A_RP = {`IDX_BLOCK_RD_PROT, 2'b00};
  localparam logic [31:0] A_DP = {`IDX_DATA_BOOT_PROT, 2'b00};
  localparam logic [31:0] A_WP = {`IDX_BLOCK_WR_PROT, 2'b00};
  logic CLK_SYS, SRST, PSEL, PENABLE, PWRITE, EXTERNAL_RESET_PIN_N, EXT_BUS_MODE;
  logic [31:0] PADDR, PWDATA;
  logic [7:0] NV_PIN_SERIAL, NV_DEBUG_BOOT, NV_BLOCK_RD_PROT, NV_DATA_BOOT_PROT, NV_BLOCK_WR_PROT;
  logic UNIT1_OUTPUT_B, UNIT1_OUTPUT_C, UNIT3_OUTPUT_B, UNIT3_OUTPUT_C, UNIT1_STEERED;
  logic CAPTURE_UNIT6, CAPTURE_UNIT7, CAPTURE_UNIT8, CAPTURE_UNIT9, UNIT3_STEERED;
  logic STACK_FULL, STACK_UNDERFLOW, PM_EXT_READ, PM_SELF_WRITE;
  logic [23:0] PM_ADDR;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, PIN_RESET_REQ, PORT_G_BIT5_IN, PORT_G_BIT5_IS_INPUT;
  wire [6:0] SERIAL_ADDR_MASK;
  wire [3:0] PORT_E_CAPTURE_OUT, PORT_E_CAPTURE_OE, PORT_H_CAPTURE_OUT, PORT_H_CAPTURE_OE;
  wire UNIT2_ON_PORT_C_BIT1, UNIT2_ON_PORT_B_BIT3, UNIT2_ON_PORT_E_BIT7, DEBUG_OWNS_PORT_B67;
  wire BOOT_SIZE_2KW, STACK_RESET_REQ, PM_READ_DENIED, PM_WRITE_DENIED, DATA_MEMORY_PROTECTED;
  // Outputs of the smallest family member watched by the bench.
  wire [3:0] SMALL_E_OE, SMALL_H_OE, SMALL_H_OUT;
  wire SMALL_RD_DENIED;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  config_fuse_bank config_fuse_bank_inst (.*);

  // Smallest member: fewer pins and less memory, sharing every input.
  config_fuse_bank #(.LARGE_MEMORY(0), .FULL_PIN_COUNT(0), .SMALL_MEMORY(1))
  config_fuse_bank_small_inst (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(), .PREADY(), .PSLVERR(),
    .NV_PIN_SERIAL(NV_PIN_SERIAL), .NV_DEBUG_BOOT(NV_DEBUG_BOOT),
    .NV_BLOCK_RD_PROT(NV_BLOCK_RD_PROT), .NV_DATA_BOOT_PROT(NV_DATA_BOOT_PROT),
    .NV_BLOCK_WR_PROT(NV_BLOCK_WR_PROT), .EXTERNAL_RESET_PIN_N(EXTERNAL_RESET_PIN_N),
    .PIN_RESET_REQ(), .PORT_G_BIT5_IN(), .PORT_G_BIT5_IS_INPUT(), .SERIAL_ADDR_MASK(),
    .UNIT1_OUTPUT_B(UNIT1_OUTPUT_B), .UNIT1_OUTPUT_C(UNIT1_OUTPUT_C),
    .UNIT3_OUTPUT_B(UNIT3_OUTPUT_B), .UNIT3_OUTPUT_C(UNIT3_OUTPUT_C),
    .CAPTURE_UNIT6(CAPTURE_UNIT6), .CAPTURE_UNIT7(CAPTURE_UNIT7),
    .CAPTURE_UNIT8(CAPTURE_UNIT8), .CAPTURE_UNIT9(CAPTURE_UNIT9),
    .UNIT1_STEERED(UNIT1_STEERED), .UNIT3_STEERED(UNIT3_STEERED),
    .PORT_E_CAPTURE_OUT(), .PORT_E_CAPTURE_OE(SMALL_E_OE),
    .PORT_H_CAPTURE_OUT(SMALL_H_OUT), .PORT_H_CAPTURE_OE(SMALL_H_OE),
    .EXT_BUS_MODE(EXT_BUS_MODE), .UNIT2_ON_PORT_C_BIT1(), .UNIT2_ON_PORT_B_BIT3(),
    .UNIT2_ON_PORT_E_BIT7(), .DEBUG_OWNS_PORT_B67(), .BOOT_SIZE_2KW(),
    .STACK_FULL(STACK_FULL), .STACK_UNDERFLOW(STACK_UNDERFLOW), .STACK_RESET_REQ(),
    .PM_ADDR(PM_ADDR), .PM_EXT_READ(PM_EXT_READ), .PM_SELF_WRITE(PM_SELF_WRITE),
    .PM_READ_DENIED(SMALL_RD_DENIED), .PM_WRITE_DENIED(), .DATA_MEMORY_PROTECTED());

  // Free-running 50 MHz clock.
  initial
  begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end

  // Cuts a hang short well past the expected run length.
  always @(posedge CLK_SYS)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      report_and_stop;
    end
  end

  task report_and_stop;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask

  // One APB transfer; the request is held until ready is seen at an edge.
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic [31:0] ed, input logic ee);
    @(posedge CLK_SYS);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, w, a, d};
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    @(posedge CLK_SYS);
    while (PREADY !== 1'b1)
      @(posedge CLK_SYS);
    if (!w)
      chk(PRDATA, ed);
    chk(PSLVERR, ee);
    {PSEL, PENABLE} <= 2'b00;
  endtask

  // Fuse bytes are only sampled while reset is held.
  task boot(input logic [7:0] ps, input logic [7:0] db, input logic [7:0] dp);
    {NV_PIN_SERIAL, NV_DEBUG_BOOT, NV_DATA_BOOT_PROT} <= {ps, db, dp};
    {NV_BLOCK_RD_PROT, NV_BLOCK_WR_PROT, SRST} <= {16'hffff, 1'b1};
    tick(2);
    SRST <= 1'b0;
    tick(2);
  endtask

  task pm(input logic r, input logic w, input logic [23:0] a, input logic er, input logic ew);
    {PM_EXT_READ, PM_SELF_WRITE, PM_ADDR} <= {r, w, a};
    tick(2);
    chk(PM_READ_DENIED, er);
    chk(PM_WRITE_DENIED, ew);
  endtask

  task cap(input logic s, input logic [3:0] p);
    {UNIT1_OUTPUT_B, UNIT1_OUTPUT_C, UNIT3_OUTPUT_B, UNIT3_OUTPUT_C} <= s ? p : 4'h0;
    {CAPTURE_UNIT6, CAPTURE_UNIT7, CAPTURE_UNIT8, CAPTURE_UNIT9} <= s ? 4'h0 : p;
    {UNIT1_STEERED, UNIT3_STEERED} <= {s, s};
    tick(2);
  endtask

  task fault(input logic f, input logic u, input logic exp);
    {STACK_FULL, STACK_UNDERFLOW} <= {f, u};
    tick(1);
    {STACK_FULL, STACK_UNDERFLOW} <= 2'b00;
    tick(1);
    chk(STACK_RESET_REQ, exp);
  endtask

  // The pin needs three edges through the synchroniser; five leaves margin.
  task pin(input logic v);
    EXTERNAL_RESET_PIN_N <= v;
    tick(5);
  endtask

  task fuses_erased;
    boot(8'hff, 8'hff, 8'hff);
    chk(SERIAL_ADDR_MASK, `SERIAL_MASK_7BIT);
    chk(PORT_G_BIT5_IS_INPUT, 1'b0);
    chk(UNIT2_ON_PORT_C_BIT1, 1'b1);
    chk(DEBUG_OWNS_PORT_B67, 1'b0);
    chk(BOOT_SIZE_2KW, 1'b1);
    chk(DATA_MEMORY_PROTECTED, 1'b0);
    xfer('0, A_PS, '0, `IMPL_PIN_SERIAL_FULL, '0);
    xfer('0, A_DB, '0, `IMPL_DEBUG_BOOT, '0);
    xfer('0, A_RP, '0, `PROT_ERASED, '0);
    xfer('0, A_DP, '0, `IMPL_DATA_BOOT, '0);
    xfer('0, A_WP, '0, `PROT_ERASED, '0);
    xfer('0, A_PS + 32'h8, '0, '0, '1);
    pin(1'b0);
    chk(PIN_RESET_REQ, 1'b1);
    pin(1'b1);
    chk(PIN_RESET_REQ, 1'b0);
    fault('1, '0, '1);
    fault('0, '1, '1);
  endtask

  // Protection bits only ever clear; the set attempt must not stick.
  task clear_only;
    xfer('1, A_PS, '0, '0, '0);
    xfer('0, A_PS, '0, `IMPL_PIN_SERIAL_FULL, '0);
    xfer('1, A_RP, 32'hfe, '0, '0);
    xfer('1, A_RP, 32'hff, '0, '0);
    xfer('0, A_RP, '0, 32'hfe, '0);
    pm('1, '0, 24'h001000, '1, '0);
    pm('1, '0, 24'h004000, '0, '0);
    xfer('1, A_RP, 32'hef, '0, '0);
    pm('1, '0, 24'h010000, '1, '0);
    chk(SMALL_RD_DENIED, 1'b0);
    xfer('1, A_WP, 32'hfb, '0, '0);
    pm('0, '1, 24'h008000, '0, '1);
    pm('0, '1, 24'h00c000, '0, '0);
    xfer('1, A_DP, 32'h80, '0, '0);
    pm('1, '0, 24'h000500, '1, '0);
  endtask

  task routing;
    for (int i = 0; i < 4; i++)
    begin
      cap('1, 4'h1 << i);
      chk(PORT_E_CAPTURE_OUT, 4'h1 << i);
      chk(PORT_E_CAPTURE_OE, 4'hf);
      chk(PORT_H_CAPTURE_OE, 4'h0);
      chk(SMALL_H_OE, 4'hf);
      chk(SMALL_E_OE, 4'h0);
      cap('0, 4'h1 << i);
      chk(PORT_E_CAPTURE_OUT, 4'h1 << i);
      chk(SMALL_H_OE, 4'ha);
      chk(SMALL_H_OUT, (4'h1 << i) & 4'ha);
    end
  endtask

  task fuses_cleared;
    boot(8'h00, 8'h00, 8'h00);
    NV_PIN_SERIAL <= 8'hff;
    tick(2);
    chk(SERIAL_ADDR_MASK, `SERIAL_MASK_5BIT);
    chk(PORT_G_BIT5_IS_INPUT, 1'b1);
    chk(DEBUG_OWNS_PORT_B67, 1'b1);
    chk(BOOT_SIZE_2KW, 1'b0);
    chk(DATA_MEMORY_PROTECTED, 1'b1);
    chk(UNIT2_ON_PORT_E_BIT7, 1'b1);
    EXT_BUS_MODE <= 1'b1;
    tick(2);
    chk(UNIT2_ON_PORT_B_BIT3, 1'b1);
    pm('1, '0, 24'h000100, '1, '0);
    pm('1, '0, 24'h000500, '0, '0);
    pin(1'b0);
    chk(PIN_RESET_REQ, 1'b0);
    chk(PORT_G_BIT5_IN, 1'b0);
    pin(1'b1);
    chk(PORT_G_BIT5_IN, 1'b1);
    fault('1, '0, '0);
    cap('1, 4'h8);
    chk(PORT_H_CAPTURE_OUT, 4'h8);
    chk(PORT_E_CAPTURE_OE, 4'h0);
  endtask

  // Main sequence; every input gets a value at time zero.
  initial
  begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= '0;
    {EXTERNAL_RESET_PIN_N, EXT_BUS_MODE, STACK_FULL, STACK_UNDERFLOW} <= 4'b1000;
    {PM_EXT_READ, PM_SELF_WRITE, PM_ADDR} <= '0;
    {UNIT1_OUTPUT_B, UNIT1_OUTPUT_C, UNIT3_OUTPUT_B, UNIT3_OUTPUT_C, UNIT1_STEERED} <= '0;
    {CAPTURE_UNIT6, CAPTURE_UNIT7, CAPTURE_UNIT8, CAPTURE_UNIT9, UNIT3_STEERED} <= '0;
    // Reset rises at time zero, so no edge ever sees it unknown.
    fuses_erased;
    clear_only;
    routing;
    fuses_cleared;
    report_and_stop;
  end
endmodule
